// ==== bench/pocr_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module pocr_checker
	import pocr_pkg::*;
(
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] owner_select_settled,
	input wire logic       owner_select_change,
	input wire pocr_host_t port1_owner,
	input wire pocr_host_t port2_owner,
	input wire logic [7:0] serial_number_string_length_out
);
	logic       own_wr;
	logic [3:0] lo_n;
	logic [3:0] hi_n;
	assign own_wr = reg_write && reg_addr == OFS_OWNER_12;
	assign lo_n = reg_wdata[3:0];
	assign hi_n = reg_wdata[7:4];
	function automatic pocr_host_t dec(input logic [3:0] n);
		return n == OWNER_NONE ? POCR_HOST_NONE : n == OWNER_HOST_TWO ? POCR_HOST_TWO : POCR_HOST_ONE;
	endfunction
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_own_wr;
		own_wr;
	endsequence
	sequence s_len_wr;
		reg_write && reg_addr == OFS_SERIAL_LENGTH;
	endsequence
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_port_one_decode: assert property (s_own_wr |-> ##2 port1_owner == dec($past(lo_n, 2)))
		else $error("port one owner decode wrong");
	a_port_two_decode: assert property (s_own_wr |-> ##2 port2_owner == dec($past(hi_n, 2)))
		else $error("port two owner decode wrong");
	a_owner_hold: assert property ($changed(port1_owner) || $changed(port2_owner) |-> $past(own_wr) || $past(own_wr, 2))
		else $error("owner moved without a write");
	a_change_pulse: assert property (owner_select_change |=> !owner_select_change)
		else $error("change pulse too long");
	a_settled_move: assert property ($changed(owner_select_settled) |-> owner_select_change)
		else $error("settled pins moved without pulse");
	a_len_clamp: assert property (serial_number_string_length_out <= SERIAL_LEN_MAX)
		else $error("length above maximum");
	a_len_write: assert property (s_len_wr |=> serial_number_string_length_out ==
		($past(reg_wdata) > SERIAL_LEN_MAX ? SERIAL_LEN_MAX : $past(reg_wdata)))
		else $error("length write wrong");
	a_len_read: assert property (reg_read && reg_addr == OFS_SERIAL_LENGTH |=> reg_rdata == serial_number_string_length_out)
		else $error("length read wrong");
endmodule
bind pocr_port_owner_config_regs pocr_checker pocr_checker_i(.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.owner_select_settled(owner_select_settled), .owner_select_change(owner_select_change),
	.port1_owner(port1_owner), .port2_owner(port2_owner),
	.serial_number_string_length_out(serial_number_string_length_out));
`default_nettype wire

// ==== bench/pocr_port_owner_config_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pocr_port_owner_config_regs_tb
	import pocr_pkg::*;
;
	logic       mclk = 1'b0;
	logic       reset = 1'b1;
	logic       reg_write = 1'b0;
	logic       reg_read = 1'b0;
	logic       go = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] bounce = 8'h00;
	logic [3:0] level = 4'h0;
	logic [7:0] reg_rdata;
	logic [7:0] len;
	logic [3:0] pins;
	logic [3:0] settled;
	logic       change;
	pocr_host_t p1;
	pocr_host_t p2;
	int         err_total = 0;
	int         samples_checked = 0;
	always #5 mclk = ~mclk;
	pocr_port_owner_config_regs #(.CYCLES_MS(10)) pocr_port_owner_config_regs_i (.mclk(mclk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .owner_select_pins(pins), .owner_select_settled(settled),
		.owner_select_change(change), .port1_owner(p1), .port2_owner(p2), .serial_number_string_length_out(len));
	pocr_switch_model pocr_switch_model_i (.mclk(mclk), .go(go), .level(level), .bounce(bounce),
		.owner_select_pins(pins));
	task chk(input logic [7:0] s, input logic [7:0] e, input string m);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("mismatch at %0t: %s seen %h want %h", $time, m, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string m);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, e, m);
	endtask
	function automatic logic [7:0] own(input int n);
		return n == 0 ? 8'h00 : n == 2 ? 8'h02 : 8'h01;
	endfunction
	task t_serial;
		#1;
		chk(8'(p1), 8'h00, "owner reset");
		rd(OFS_OWNER_12, 8'h00, "owner reg reset");
		rd(OFS_DEBOUNCE, 8'h00, "delay reset");
		rd(OFS_SERIAL_LENGTH, 8'h00, "length reset");
		for (int k = 0; k < SERIAL_BYTES; k++)
			rd(OFS_SERIAL_FIRST + 8'(k), 8'h00, "serial reset");
		for (int k = 0; k < SERIAL_CHARS; k++) begin
			wr(OFS_SERIAL_FIRST + 8'(2 * k), 8'(k));
			wr(OFS_SERIAL_FIRST + 8'(2 * k + 1), 8'(8'hc0 + k));
		end
		for (int k = 0; k < SERIAL_CHARS; k++) begin
			rd(OFS_SERIAL_FIRST + 8'(2 * k), 8'(k), "char low");
			rd(OFS_SERIAL_FIRST + 8'(2 * k + 1), 8'(8'hc0 + k), "char high");
		end
		rd(8'h91, 8'h00, "below area");
		$display("t_serial done");
	endtask
	task t_owner;
		for (int n = 0; n < 16; n++) begin
			wr(OFS_OWNER_12, {4'(n), 4'(15 - n)});
			@(posedge mclk);
			#1;
			chk(8'(p1), own(15 - n), "port one owner");
			chk(8'(p2), own(n), "port two owner");
			rd(OFS_OWNER_12, {4'(n), 4'(15 - n)}, "owner read back");
		end
		$display("t_owner done");
	endtask
	task t_length;
		wr(OFS_SERIAL_LENGTH, 8'h1f);
		rd(OFS_SERIAL_LENGTH, 8'h1f, "length max");
		wr(OFS_SERIAL_LENGTH, 8'h20);
		rd(OFS_SERIAL_LENGTH, 8'h1f, "length clamp");
		chk(len, 8'h1f, "length out");
		$display("t_length done");
	endtask
	task t_debounce;
		int n;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_DEBOUNCE, 8'(3 * i));
			rd(OFS_DEBOUNCE, 8'(3 * i), "delay read back");
			@(posedge mclk);
			level <= 4'h5 + 4'(5 * i);
			bounce <= i ? 8'h06 : 8'h01;
			go <= 1'b1;
			@(posedge mclk);
			go <= 1'b0;
			n = 0;
			while (change !== 1'b1 && n < 5000) begin
				@(posedge mclk);
				#1;
				n++;
				if (i == 1 && n == 20) begin
					rd(OFS_STATUS, {4'h1, ~level}, "status busy");
					n = n + 2;
				end
			end
			chk(8'(n >= 35 * i), 8'h01, "switched too early");
			chk(8'(n <= 30 * i + 16), 8'h01, "switched too late");
			chk(8'(settled), 8'(level), "settled pins");
			rd(OFS_STATUS, 8'(level), "status pins");
		end
		$display("t_debounce done");
	endtask
	task give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		t_serial;
		t_owner;
		t_length;
		t_debounce;
		give_verdict;
	end
	initial begin
		#50000;
		err_total++;
		give_verdict;
	end
endmodule
`default_nettype wire

// ==== bench/pocr_switch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pocr_switch_model (
	input wire logic       mclk,
	input wire logic       go,
	input wire logic [3:0] level,
	input wire logic [7:0] bounce,
	output logic     [3:0] owner_select_pins
);
	logic [7:0] left_reg = 8'h00;
	initial owner_select_pins = 4'h0;
	always @(posedge mclk) begin
		if (go)
			left_reg <= bounce;
		else if (left_reg != 8'h00)
			left_reg <= left_reg - 8'h01;
		if (left_reg > 8'h01)
			owner_select_pins <= left_reg[0] ? level : ~level;
		else if (left_reg == 8'h01)
			owner_select_pins <= level;
	end
endmodule
`default_nettype wire

// ==== core/pocr_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
module pocr_debounce
	import pocr_pkg::*;
#(
	parameter int CYCLES_MS = CYCLES_PER_MS
)(
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [7:0]       delay_ms,
	input  wire logic [PIN_W-1:0] pins_in,
	output logic      [PIN_W-1:0] pins_settled,
	output logic                  settle_pulse,
	output logic                  busy
);

	pocr_state_t      state_reg;
	logic [PIN_W-1:0] sample_reg;
	logic [31:0]      tick_reg;
	logic [7:0]       ms_reg;
	logic             ms_done;

	assign ms_done = (tick_reg == 32'(CYCLES_MS - 1));
	assign busy    = (state_reg != POCR_IDLE);

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg  <= POCR_IDLE;
			sample_reg <= '0;
			tick_reg   <= '0;
			ms_reg     <= '0;
		end else begin
			unique case (state_reg)
				POCR_IDLE: begin
					if (pins_in != pins_settled) begin
						sample_reg <= pins_in;
						tick_reg   <= '0;
						ms_reg     <= '0;
						state_reg  <= (delay_ms == REG_RESET) ? POCR_COMMIT : POCR_WAIT;
					end
				end
				POCR_WAIT: begin
					if (pins_in != sample_reg) begin
						sample_reg <= pins_in;
						tick_reg   <= '0;
						ms_reg     <= '0;
					end else if (ms_done) begin
						tick_reg <= '0;
						ms_reg   <= ms_reg + 8'h01;
						if (ms_reg + 8'h01 >= delay_ms) begin
							state_reg <= POCR_COMMIT;
						end
					end else begin
						tick_reg <= tick_reg + 32'h1;
					end
				end
				POCR_COMMIT: begin
					state_reg <= POCR_IDLE;
				end
				default: begin
					state_reg <= POCR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pins_settled <= '0;
			settle_pulse <= 1'b0;
		end else begin
			settle_pulse <= (state_reg == POCR_COMMIT);
			if (state_reg == POCR_COMMIT) begin
				pins_settled <= sample_reg;
			end
		end
	end

endmodule
`default_nettype wire

// ==== core/pocr_port_owner_config_regs.sv ====
// Notes on behaviour
// - serial string holds 31 chars, 62 bytes
// - char low byte first, high next
// - all serial bytes reset to zero
// - wait programmed ms after pin change
// - delay debounces the four select pins
// - delay register 8 bits, resets zero
// - high nibble port two, low port one
// - reserved owner codes mean host one
// - owner register resets to unassigned
// - length register, maximum 31 characters
`timescale 1ns/1ps
`default_nettype none
module pocr_port_owner_config_regs
	import pocr_pkg::*;
#(
	parameter int CYCLES_MS = CYCLES_PER_MS
)(
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_write,
	input  wire logic             reg_read,
	output logic      [7:0]       reg_rdata,
	input  wire logic [PIN_W-1:0] owner_select_pins,
	output logic      [PIN_W-1:0] owner_select_settled,
	output logic                  owner_select_change,
	output pocr_host_t            port1_owner,
	output pocr_host_t            port2_owner,
	output logic      [7:0]       serial_number_string_length_out
);

	// ***************************************************
	// decode helpers
	// ***************************************************
	function automatic pocr_host_t owner_decode(input logic [3:0] code);
		pocr_host_t h;
		h = POCR_HOST_ONE;
		unique case (code)
			OWNER_NONE:     h = POCR_HOST_NONE;
			OWNER_HOST_ONE: h = POCR_HOST_ONE;
			OWNER_HOST_TWO: h = POCR_HOST_TWO;
			default:        h = POCR_HOST_ONE;
		endcase
		return h;
	endfunction

	function automatic logic in_serial(input logic [7:0] a);
		return (a >= OFS_SERIAL_FIRST) && (a <= OFS_SERIAL_LAST);
	endfunction

	// ***************************************************
	// registers
	// ***************************************************
	logic [7:0]           switch_debounce_delay_reg;
	logic [7:0]           ports_one_two_owner_reg;
	logic [7:0]           serial_number_string_length_reg;
	logic [7:0]           rd_addr_reg;
	logic                 rd_pend_reg;
	logic [7:0]           direct_rdata_reg;
	logic [7:0]           serial_rdata;
	logic [SERIAL_AW-1:0] serial_wr_idx;
	logic [SERIAL_AW-1:0] serial_rd_idx;
	logic                 serial_wr;
	logic                 db_busy;

	assign serial_wr_idx = SERIAL_AW'(reg_addr - OFS_SERIAL_FIRST);
	assign serial_rd_idx = serial_wr_idx;
	assign serial_wr     = reg_write && in_serial(reg_addr);

	always_ff @(posedge mclk) begin
		if (reset) begin
			switch_debounce_delay_reg <= REG_RESET;
		end else if (reg_write && reg_addr == OFS_DEBOUNCE) begin
			switch_debounce_delay_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ports_one_two_owner_reg <= REG_RESET;
		end else if (reg_write && reg_addr == OFS_OWNER_12) begin
			ports_one_two_owner_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			serial_number_string_length_reg <= REG_RESET;
		end else if (reg_write && reg_addr == OFS_SERIAL_LENGTH) begin
			serial_number_string_length_reg <= (reg_wdata > SERIAL_LEN_MAX) ? SERIAL_LEN_MAX : reg_wdata;
		end
	end

	assign serial_number_string_length_out = serial_number_string_length_reg;

	// ***************************************************
	// serial string storage
	// ***************************************************
	// byte addressed, low byte first
	pocr_serial_mem u_serial (
		.mclk    (mclk),
		.reset   (reset),
		.wr_en   (serial_wr),
		.wr_addr (serial_wr_idx),
		.wr_data (reg_wdata),
		.rd_addr (serial_rd_idx),
		.rd_data (serial_rdata)
	);

	// ***************************************************
	// read path
	// ***************************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			rd_addr_reg      <= REG_RESET;
			rd_pend_reg      <= 1'b0;
			direct_rdata_reg <= READ_UNMAPPED;
		end else begin
			rd_pend_reg <= reg_read;
			rd_addr_reg <= reg_addr;
			if (reg_read) begin
				if (reg_addr == OFS_DEBOUNCE) begin
					direct_rdata_reg <= switch_debounce_delay_reg;
				end else if (reg_addr == OFS_OWNER_12) begin
					direct_rdata_reg <= ports_one_two_owner_reg;
				end else if (reg_addr == OFS_SERIAL_LENGTH) begin
					direct_rdata_reg <= serial_number_string_length_reg;
				end else if (reg_addr == OFS_STATUS) begin
					direct_rdata_reg <= {3'h0, db_busy, owner_select_settled};
				end else begin
					direct_rdata_reg <= READ_UNMAPPED;
				end
			end
		end
	end

	always_comb begin
		if (!rd_pend_reg) begin
			reg_rdata = READ_UNMAPPED;
		end else if (in_serial(rd_addr_reg)) begin
			reg_rdata = serial_rdata;
		end else begin
			reg_rdata = direct_rdata_reg;
		end
	end

	// ***************************************************
	// pin debounce
	// ***************************************************
	// delay in ms before switching
	pocr_debounce #(
		.CYCLES_MS (CYCLES_MS)
	) u_debounce (
		.mclk         (mclk),
		.reset        (reset),
		.delay_ms     (switch_debounce_delay_reg),
		.pins_in      (owner_select_pins),
		.pins_settled (owner_select_settled),
		.settle_pulse (owner_select_change),
		.busy         (db_busy)
	);

	// ***************************************************
	// owner outputs
	// ***************************************************
	// nibble per port
	always_ff @(posedge mclk) begin
		if (reset) begin
			port1_owner <= POCR_HOST_NONE;
			port2_owner <= POCR_HOST_NONE;
		end else begin
			port1_owner <= owner_decode(ports_one_two_owner_reg[PORT1_LSB +: NIBBLE_W]);
			port2_owner <= owner_decode(ports_one_two_owner_reg[PORT2_LSB +: NIBBLE_W]);
		end
	end

endmodule
`default_nettype wire

// ==== core/pocr_serial_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module pocr_serial_mem
	import pocr_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 wr_en,
	input  wire logic [SERIAL_AW-1:0] wr_addr,
	input  wire logic [7:0]           wr_data,
	input  wire logic [SERIAL_AW-1:0] rd_addr,
	output logic      [7:0]           rd_data
);

	logic [7:0] mem_reg [SERIAL_BYTES];

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < SERIAL_BYTES; i++) begin
				mem_reg[i] <= REG_RESET;
			end
		end else if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rd_data <= REG_RESET;
		end else begin
			rd_data <= mem_reg[rd_addr];
		end
	end

endmodule
`default_nettype wire

// ==== shared/pocr_pkg.sv ====
package pocr_pkg;

	// ***************************************************
	// register map
	// ***************************************************
	localparam logic [7:0] OFS_SERIAL_FIRST  = 8'h92;
	localparam logic [7:0] OFS_SERIAL_LAST   = 8'hcf;
	localparam logic [7:0] OFS_DEBOUNCE      = 8'hd0;
	localparam logic [7:0] OFS_OWNER_12      = 8'hd1;
	localparam logic [7:0] OFS_SERIAL_LENGTH = 8'h15;
	localparam logic [7:0] OFS_STATUS        = 8'he0;

	localparam int         SERIAL_CHARS      = 31;
	localparam int         SERIAL_BYTES      = 62;
	localparam int         SERIAL_AW         = 6;
	localparam logic [7:0] SERIAL_LEN_MAX    = 8'h1f;
	localparam logic [7:0] REG_RESET         = 8'h00;
	localparam logic [7:0] READ_UNMAPPED     = 8'h00;

	// ***************************************************
	// owner nibble codes
	// ***************************************************
	localparam logic [3:0] OWNER_NONE        = 4'h0;
	localparam logic [3:0] OWNER_HOST_ONE    = 4'h1;
	localparam logic [3:0] OWNER_HOST_TWO    = 4'h2;
	localparam int         PORT1_LSB         = 0;
	localparam int         PORT2_LSB         = 4;
	localparam int         NIBBLE_W          = 4;

	typedef enum logic [1:0] {
		POCR_HOST_NONE = 2'h0,
		POCR_HOST_ONE  = 2'h1,
		POCR_HOST_TWO  = 2'h2
	} pocr_host_t;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int CLK_MHZ       = 100;
	localparam int MS_US         = 1000;
	localparam int CYCLES_PER_MS = CLK_MHZ * MS_US;
	localparam int PIN_W         = 4;

	typedef enum logic [1:0] {
		POCR_IDLE   = 2'b00,
		POCR_WAIT   = 2'b01,
		POCR_COMMIT = 2'b11
	} pocr_state_t;

endpackage
